// ==== core/rfbp_pkg.sv ====
// Package for the receive frame buffer protection block.
// Assumes an internal register port addressed by 6-bit register offsets.
package rfbp_pkg;
    localparam logic [5:0] RFBP_ADDR_RX_MISC_CONTROL = 6'h0c;
    localparam int         RFBP_SAFE_BIT             = 7;
    // Reset image of the control register: bit 5 set, the rest clear
    localparam logic [7:0] RFBP_MISC_RESET           = 8'h20;
    // Writable bits of the control register (bits 7, 5, 2, 1, 0)
    localparam logic [7:0] RFBP_MISC_WMASK           = 8'ha7;

    typedef enum logic [1:0] {
        RFBP_ST_OTHER,
        RFBP_ST_RX_LISTEN,
        RFBP_ST_RX_AUTO_ACK
    } rfbp_trx_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } rfbp_reg_req_t;

    typedef struct packed {
        logic       we;
        logic [6:0] addr;
        logic [7:0] data;
    } rfbp_buf_wr_t;
endpackage : rfbp_pkg

// ==== core/rfbp_top.sv ====
// Receive frame buffer protection: gates air-side writes into the frame buffer.
// Assumes the receive path, SPI decoder and state control supply pulses in i_sys_clk.
//
// How it works
// - In receive states frames keep arriving; without protection each overwrites buffer.
// - While protected, new air frames stay out until chip select rises after a buffer read.
// - Basic mode: protection begins when stored frame's FCS checks valid.
// - Extended mode: protection begins when the frame-end interrupt is raised.
// - Protection arms only with enable bit set and in a receive state.
// - Only air-side writes are blocked; SPI buffer writes always pass.
// - Enable is bit 7 of register 0x0c, read/write, reset zero.
// - Release on chip select rising after buffer read, or leaving receive.
// - Behaviour ignores the receiver sensitivity threshold setting.
`timescale 1ns/10ps
module rfbp_top
    import rfbp_pkg::*;
(
    // Clock and reset
    input  wire logic            i_sys_clk,
    input  wire logic            i_rstn,
    // Register port
    input  wire rfbp_reg_req_t   i_reg_req,
    output logic [7:0]           o_reg_rdata,
    // Transceiver state and receive events
    input  wire rfbp_trx_state_t i_trx_state,
    input  wire logic            i_extended_mode,
    input  wire logic            i_rx_frame_start,
    input  wire logic            i_rx_fcs_valid,
    input  wire logic            i_frame_end_event,
    input  wire logic [3:0]      i_rx_sensitivity_threshold,
    // Frame buffer write sources
    input  wire rfbp_buf_wr_t    i_air_wr,
    input  wire rfbp_buf_wr_t    i_spi_wr,
    // Host chip select and buffer read marker
    input  wire logic            i_spi_sel_n,
    input  wire logic            i_spi_buf_read,
    // Gated frame buffer write port
    output rfbp_buf_wr_t         o_buf_wr,
    output logic                 o_protect_active
);
    logic       rst_s1_q, rst_n;
    logic [7:0] misc_q, misc_d;
    logic       prot_q, prot_d;
    logic       drop_q, drop_d;
    logic       bufrd_q, bufrd_d;
    logic       sel_n_q;
    logic       in_rx, sel_rise, accept, release_ev;
    rfbp_buf_wr_t buf_d, buf_q;
    logic [7:0]   rdata_d;

    // Reset asserts at once but releases on the clock, so no flop leaves reset a cycle late
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    assign in_rx = (i_trx_state == RFBP_ST_RX_LISTEN) || (i_trx_state == RFBP_ST_RX_AUTO_ACK);
    assign sel_rise = i_spi_sel_n && !sel_n_q;
    assign accept = i_extended_mode ? i_frame_end_event : i_rx_fcs_valid;
    assign release_ev = !in_rx || (sel_rise && bufrd_q);

    always_comb begin
        misc_d  = misc_q;
        prot_d  = prot_q;
        drop_d  = drop_q;
        bufrd_d = bufrd_q;
        rdata_d = 8'h00;
        if (i_reg_req.wr && i_reg_req.addr == RFBP_ADDR_RX_MISC_CONTROL) begin
            misc_d = (misc_q & ~RFBP_MISC_WMASK) | (i_reg_req.wdata & RFBP_MISC_WMASK);
        end
        if (i_reg_req.rd && i_reg_req.addr == RFBP_ADDR_RX_MISC_CONTROL) begin
            rdata_d = misc_q;
        end
        // Marks the current select as a frame buffer read
        if (i_spi_buf_read && !i_spi_sel_n) begin
            bufrd_d = 1'b1;
        end else if (i_spi_sel_n) begin
            bufrd_d = 1'b0;
        end
        if (release_ev) begin
            prot_d = 1'b0;
        end
        // arm only when enabled in receive
        // Dropped frames never arm: nothing of theirs was stored
        if (accept && misc_q[RFBP_SAFE_BIT] && in_rx && !drop_q) begin
            prot_d = 1'b1;
        end
        // drop frames starting under protection
        // Whole frame stays out even if the read ends mid-frame
        if (i_rx_frame_start) begin
            drop_d = prot_q && !release_ev;
        end
        if (!in_rx) begin
            drop_d = 1'b0;
        end
    end

    always_comb begin
        buf_d = '0;
        // Trade-off: an air byte colliding with a host write is lost
        // host writes take priority and pass
        if (i_spi_wr.we) begin
            buf_d = i_spi_wr;
        end else if (i_air_wr.we && !prot_q && !drop_q) begin
            buf_d = i_air_wr;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            misc_q      <= RFBP_MISC_RESET;
            prot_q      <= 1'b0;
            drop_q      <= 1'b0;
            bufrd_q     <= 1'b0;
            sel_n_q     <= 1'b1;
            buf_q       <= '0;
            o_reg_rdata <= 8'h00;
        end else begin
            misc_q      <= misc_d;
            prot_q      <= prot_d;
            drop_q      <= drop_d;
            bufrd_q     <= bufrd_d;
            sel_n_q     <= i_spi_sel_n;
            buf_q       <= buf_d;
            o_reg_rdata <= rdata_d;
        end
    end

    assign o_buf_wr         = buf_q;
    assign o_protect_active = prot_q;

    a_air_blocked: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (prot_q && i_air_wr.we && !i_spi_wr.we) |=> !o_buf_wr.we)
        else $error("air write passed while protected");
    a_prot_holds: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (prot_q && in_rx && !(sel_rise && bufrd_q)) |=> prot_q)
        else $error("protection dropped before read end");
    a_spi_passes: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        i_spi_wr.we |=> (o_buf_wr.we && o_buf_wr.data == $past(i_spi_wr.data)))
        else $error("spi write not passed");
    a_leave_rx: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        !in_rx |=> !prot_q)
        else $error("protection held outside receive");
    a_rdflag_clear: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        i_spi_sel_n |=> !bufrd_q)
        else $error("buffer read flag outlived select");
    a_disabled_arm: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (!prot_q && !misc_q[RFBP_SAFE_BIT]) |=> !prot_q)
        else $error("armed while disabled");
    a_basic_arm: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (!i_extended_mode && i_rx_fcs_valid && misc_q[RFBP_SAFE_BIT] && in_rx && !drop_q)
        |=> prot_q)
        else $error("basic mode did not arm");
    a_ext_arm: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (i_extended_mode && i_frame_end_event && misc_q[RFBP_SAFE_BIT] && in_rx && !drop_q)
        |=> prot_q)
        else $error("extended mode did not arm");
    a_open_write: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (!prot_q && !drop_q && i_air_wr.we) |=> o_buf_wr.we)
        else $error("unprotected air write lost");
    a_air_lands: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (!prot_q && !drop_q && i_air_wr.we && !i_spi_wr.we)
        |=> (o_buf_wr == $past(i_air_wr)))
        else $error("unprotected air write altered");
    a_enable_reg: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (i_reg_req.wr && i_reg_req.addr == RFBP_ADDR_RX_MISC_CONTROL)
        |=> misc_q[RFBP_SAFE_BIT] == $past(i_reg_req.wdata[RFBP_SAFE_BIT]))
        else $error("enable bit not written");
    a_reg_read: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (i_reg_req.rd && i_reg_req.addr == RFBP_ADDR_RX_MISC_CONTROL)
        |=> o_reg_rdata == $past(misc_q))
        else $error("control register read wrong");
    a_other_read: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (i_reg_req.rd && i_reg_req.addr != RFBP_ADDR_RX_MISC_CONTROL)
        |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ro_bits: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        i_reg_req.wr
        |=> ((misc_q & ~RFBP_MISC_WMASK) == ($past(misc_q) & ~RFBP_MISC_WMASK)))
        else $error("read-only control bits changed");
    a_drop_start: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (i_rx_frame_start && prot_q && in_rx && !(sel_rise && bufrd_q)) |=> drop_q)
        else $error("frame under protection not marked");
    a_drop_frame: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (drop_q && i_air_wr.we && !i_spi_wr.we) |=> !o_buf_wr.we)
        else $error("dropped frame stored");
    a_sel_release: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (prot_q && bufrd_q && sel_rise && !accept) |=> !prot_q)
        else $error("chip select did not release");

    // Main scenarios
    c_arm: cover property (@(posedge i_sys_clk) disable iff (!rst_n) !prot_q ##1 prot_q);
    c_release: cover property (@(posedge i_sys_clk) disable iff (!rst_n)
        prot_q && bufrd_q && sel_rise);
    c_blocked: cover property (@(posedge i_sys_clk) disable iff (!rst_n)
        prot_q && i_air_wr.we);
    c_dropped: cover property (@(posedge i_sys_clk) disable iff (!rst_n)
        drop_q && !prot_q && i_air_wr.we);
    c_leave_rx: cover property (@(posedge i_sys_clk) disable iff (!rst_n)
        prot_q && !in_rx);
endmodule : rfbp_top

// ==== tb/rfbp_host.sv ====
// Host model: register accesses, chip select and SPI buffer writes.
// Assumes callers enter its tasks just after a falling clock edge.
`timescale 1ns/10ps
module rfbp_host
    import rfbp_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    output rfbp_reg_req_t   o_req,
    output rfbp_buf_wr_t    o_spi_wr,
    output logic            o_sel_n,
    output logic            o_buf_read
);
    initial begin
        o_req      = '0;
        o_spi_wr   = '0;
        o_sel_n    = 1'b1;
        o_buf_read = 1'b0;
    end
    // Answer taken one edge after the request, then one idle edge between calls
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] r);
        o_req = '{w, !w, a, d};
        @(negedge i_clk);
        r     = i_rdata;
        o_req = '0;
        @(negedge i_clk);
    endtask : acc
    task automatic sw(input logic [7:0] d);
        o_spi_wr = '{1'b1, 7'h00, d};
        @(negedge i_clk);
        o_spi_wr = '0;
        @(negedge i_clk);
    endtask : sw
    task automatic bread(input logic b);
        o_sel_n    = 1'b0;
        o_buf_read = b;
        @(negedge i_clk);
        o_buf_read = 1'b0;
        o_sel_n    = 1'b1;
        @(negedge i_clk);
    endtask : bread
endmodule : rfbp_host

// ==== tb/rfbp_top_tb.sv ====
// Self-checking bench for the frame buffer protection block.
// Assumes rfbp_host drives the host side; stimulus changes at falling edges.
`timescale 1ns/10ps
module rfbp_top_tb;
    import rfbp_pkg::*;
    logic            clk = 1'b0, rstn = 1'b0, ext = 1'b0, fs = 1'b0, fcs = 1'b0, fe = 1'b0;
    logic [3:0]      thr = 4'h0;
    rfbp_trx_state_t st  = RFBP_ST_OTHER;
    rfbp_buf_wr_t    air = '0, spi, obw;
    rfbp_reg_req_t   req;
    logic            sel_n, brd, pa;
    logic [7:0]      rd, rv;
    rfbp_buf_wr_t    q[$];
    int              err_total = 0, tests_run = 0, seed = 97333;
    initial forever #2 clk = !clk;
    rfbp_top i_dut (.i_sys_clk(clk), .i_rstn(rstn), .i_reg_req(req), .o_reg_rdata(rd),
        .i_trx_state(st), .i_extended_mode(ext), .i_rx_frame_start(fs),
        .i_rx_fcs_valid(fcs), .i_frame_end_event(fe), .i_rx_sensitivity_threshold(thr),
        .i_air_wr(air), .i_spi_wr(spi), .i_spi_sel_n(sel_n), .i_spi_buf_read(brd),
        .o_buf_wr(obw), .o_protect_active(pa));
    rfbp_host h (.i_clk(clk), .i_rdata(rd), .o_req(req), .o_spi_wr(spi), .o_sel_n(sel_n),
        .o_buf_read(brd));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic close_out();
        if (err_total == 0 && tests_run > 0 && q.size() == 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    // One air frame of one byte; noted only when it should land
    task automatic af(input logic ok);
        fs = 1'b1;
        @(negedge clk);
        fs  = 1'b0;
        air = '{1'b1, 7'($random(seed)), 8'($random(seed))};
        if (ok) q.push_back(air);
        @(negedge clk);
        air = '0;
    endtask : af
    task automatic arm(input logic by_fe, input logic e);
        fe  = by_fe;
        fcs = !by_fe;
        @(negedge clk);
        fe  = 1'b0;
        fcs = 1'b0;
        @(negedge clk);
        chk("protect", {15'h0, e}, {15'h0, pa});
    endtask : arm
    always @(negedge clk) if (obw.we !== 1'b0) begin
        if (q.size() == 0) chk("buf_wr", 16'h0, obw);
        else chk("buf_wr", q.pop_front(), obw);
    end
    initial begin
        #20000;
        err_total++;
        close_out();
    end
    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        h.acc(1'b0, RFBP_ADDR_RX_MISC_CONTROL, 8'h00, rv);
        chk("misc", {8'h0, RFBP_MISC_RESET}, {8'h0, rv});
        h.acc(1'b1, RFBP_ADDR_RX_MISC_CONTROL, 8'hff, rv);
        h.acc(1'b0, RFBP_ADDR_RX_MISC_CONTROL, 8'h00, rv);
        chk("misc", {8'h0, RFBP_MISC_WMASK}, {8'h0, rv});
        h.acc(1'b0, 6'h15, 8'h00, rv);
        chk("unmapped", 16'h0, {8'h0, rv});
        for (int m = 0; m < 4; m++) begin
            ext = m[0];
            st  = m[1] ? RFBP_ST_RX_AUTO_ACK : RFBP_ST_RX_LISTEN;
            thr = 4'($random(seed));
            af(1'b1);
            if (!ext) arm(1'b1, 1'b0);
            else arm(1'b0, 1'b0);
            arm(ext, 1'b1);
            af(1'b0);
            q.push_back('{1'b1, 7'h00, 8'h5a});
            h.sw(8'h5a);
            // Select without a buffer read must not release
            h.bread(1'b0);
            repeat (2) @(negedge clk);
            chk("hold", 16'h1, {15'h0, pa});
            if (m[1]) st = RFBP_ST_OTHER;
            else h.bread(1'b1);
            repeat (2) @(negedge clk);
            chk("release", 16'h0, {15'h0, pa});
            st = RFBP_ST_RX_LISTEN;
            af(1'b1);
        end
        // Frame begun under protection stays out after release
        arm(ext, 1'b1);
        fs = 1'b1;
        @(negedge clk);
        fs = 1'b0;
        h.bread(1'b1);
        air = '{1'b1, 7'($random(seed)), 8'($random(seed))};
        @(negedge clk);
        air = '0;
        chk("release", 16'h0, {15'h0, pa});
        h.acc(1'b1, RFBP_ADDR_RX_MISC_CONTROL, 8'h00, rv);
        af(1'b1);
        arm(ext, 1'b0);
        af(1'b1);
        h.acc(1'b1, RFBP_ADDR_RX_MISC_CONTROL, 8'h80, rv);
        st = RFBP_ST_OTHER;
        arm(ext, 1'b0);
        repeat (3) @(negedge clk);
        close_out();
    end
endmodule : rfbp_top_tb
